// *** hw/edr_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module edr_core (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    input  wire logic                           clk_en,
    // external pins
    input  wire logic                           dma_req_n,
    output logic                                dma_gnt_n,
    // channel configuration
    input  wire logic [edr_pkg::EDR_SRC_W-1:0]  request_source_select,
    input  wire logic [edr_pkg::EDR_SRC_W-1:0]  ext_source_code,
    input  wire logic                           request_enable,
    input  wire logic                           channel_enable,
    // arbiter side of dma_controller
    input  wire logic                           other_req,
    input  wire logic                           chan_top,
    output logic                                chan_req,
    output logic                                chan_low_pri,
    input  wire logic                           burst_start,
    input  wire logic                           burst_done,
    output logic                                burst_active
);
    import edr_pkg::*;

    edr_sync_if sif ();
    edr_state_t state_q;
    logic [EDR_CNT_W-1:0] cnt_q;
    logic gnt_q;
    logic low_pri_q;
    logic cfg_ok;
    logic done_ok;

    edr_sync u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    assign sif.req_raw_n = dma_req_n;
    assign sif.hold      = gnt_q;
    assign cfg_ok = (request_source_select == ext_source_code) && request_enable && channel_enable;
    assign done_ok = burst_done && (cnt_q == '0);
    assign chan_req = (state_q == EDR_WAIT) && sif.req_sync && cfg_ok;
    assign chan_low_pri = low_pri_q && other_req;
    assign burst_active = gnt_q;
    assign dma_gnt_n = ~gnt_q;

    // ****************************************
    // handshake sequencer
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= EDR_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                EDR_IDLE: begin
                    if (sif.req_sync) begin
                        state_q <= EDR_WAIT;
                    end
                end
                EDR_WAIT: begin
                    // start only as top channel with all qualifiers true
                    if (!sif.req_sync) begin
                        state_q <= EDR_IDLE;
                    end else if (burst_start && chan_top && cfg_ok) begin
                        state_q <= EDR_BURST;
                    end
                end
                EDR_BURST: begin
                    if (done_ok) begin
                        state_q <= EDR_DONE;
                    end
                end
                EDR_DONE: begin
                    state_q <= EDR_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // grant and minimum width
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gnt_q <= ~EDR_GNT_RST_N;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (state_q == EDR_WAIT && sif.req_sync && burst_start && chan_top && cfg_ok) begin
                gnt_q <= 1'b1;
                cnt_q <= EDR_GNT_MIN_CNT - 4'h1;
            end else if (state_q == EDR_BURST) begin
                if (cnt_q != '0) begin
                    cnt_q <= cnt_q - 4'h1;
                end
                if (done_ok) begin
                    gnt_q <= 1'b0;
                end
            end
        end
    end

    // priority drop after a burst: set by the done state, cleared by a burst start while not granted
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            low_pri_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == EDR_DONE) begin
                low_pri_q <= 1'b1;
            end else if (gnt_q == 1'b0 && burst_start) begin
                low_pri_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    chk_gnt_min_width: assert property ($rose(gnt_q) && clk_en |-> gnt_q [*8])
        else $error("grant shorter than minimum");
    chk_gnt_qualify: assert property ($rose(gnt_q) |-> $past(cfg_ok) && $past(chan_top))
        else $error("grant without qualifiers");
    chk_gnt_pin: assert property (dma_gnt_n == !gnt_q)
        else $error("grant pin polarity");
    chk_sync_frozen: assert property (gnt_q && $past(gnt_q) |-> $stable(sif.req_sync))
        else $error("sync moved during burst");
    chk_one_burst: assert property ($fell(gnt_q) |-> state_q == EDR_DONE ##1 !gnt_q)
        else $error("back to back grant");
    chk_gnt_release: assert property (gnt_q && done_ok && clk_en |=> !gnt_q)
        else $error("grant not released");
    chk_low_pri: assert property ($past(state_q) == EDR_DONE && other_req |-> chan_low_pri)
        else $error("priority not lowered");
    chk_no_req_gnt: assert property ($rose(gnt_q) |-> $past(sif.req_sync))
        else $error("grant without request");

    cov_burst: cover property ($rose(gnt_q) ##[8:40] $fell(gnt_q));
    cov_drop: cover property (state_q == EDR_WAIT ##1 state_q == EDR_IDLE);
    cov_low_pri: cover property (chan_low_pri);
endmodule // edr_core
`default_nettype wire

// *** hw/edr_pkg.sv ***
package edr_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned EDR_CLK_MHZ         = 40;
    localparam int unsigned EDR_GNT_MIN_HCLK    = 8;
    localparam int unsigned EDR_REQ_REL_HCLK    = 9;
    localparam int unsigned EDR_READ_REL_HCLK   = 8;
    localparam int unsigned EDR_WRITE_REL_HCLK  = 3;
    localparam int unsigned EDR_CNT_W           = 4;
    localparam logic [3:0]  EDR_GNT_MIN_CNT     = 4'(EDR_GNT_MIN_HCLK);
    // ****************************************
    // reset values and channel config
    // ****************************************
    localparam int unsigned EDR_SRC_W           = 5;
    localparam logic        EDR_GNT_RST_N       = 1'b1;
    localparam logic        EDR_SYNC_RST        = 1'b0;

    typedef enum logic [1:0] {
        EDR_IDLE,
        EDR_WAIT,
        EDR_BURST,
        EDR_DONE
    } edr_state_t;
endpackage

// *** hw/edr_sync_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// synchroniser carrier
// ****************************************
interface edr_sync_if;
    logic req_raw_n;
    logic hold;
    logic req_sync;
    modport sync (input req_raw_n, input hold, output req_sync);
    modport core (output req_raw_n, output hold, input req_sync);
endinterface
`default_nettype wire

// *** hw/edr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module edr_sync (
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   srst,
    input  wire logic   clk_en,
    // carrier
    edr_sync_if.sync    sif
);
    import edr_pkg::*;
    logic meta_q;
    logic req_q;

    // frozen while granted, so the pre-grant request is still seen for two cycles afterwards
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= EDR_SYNC_RST;
            req_q  <= EDR_SYNC_RST;
        end else if (clk_en && !sif.hold) begin
            meta_q <= ~sif.req_raw_n;
            req_q  <= meta_q;
        end
    end
    assign sif.req_sync = req_q;
endmodule // edr_sync
`default_nettype wire

// *** verif/edr_periph.sv ***
`timescale 1ns/100ps
`default_nettype none
module edr_periph (
    // clock, grant and go
    input  wire logic clk_sys,
    input  wire logic dma_gnt_n,
    input  wire logic go,
    // request pin
    output logic      dma_req_n
);
    logic [3:0] cnt_q;
    initial dma_req_n = 1'b1;
    initial cnt_q = 4'h0;
    // release two cycles into grant, well inside the limit
    always @(posedge clk_sys) begin
        if (go) begin
            dma_req_n <= #1 1'b0;
        end else if (!dma_gnt_n && !dma_req_n) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1) begin
                dma_req_n <= #1 1'b1;
            end
        end else begin
            cnt_q <= 4'h0;
        end
    end
endmodule // edr_periph
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic go = 1'b0;
    logic dma_req_n, dma_gnt_n, chan_req, chan_low_pri, burst_active;
    logic [4:0] src_sel = 5'h00;
    logic req_en = 1'b1, chan_en = 1'b0, other_req = 1'b1, chan_top = 1'b0;
    logic clk_en = 1'b1;
    logic burst_start = 1'b0, burst_done = 1'b0;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk_sys = ~clk_sys;
    edr_core u_edr_core (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
        .dma_req_n(dma_req_n), .dma_gnt_n(dma_gnt_n), .request_source_select(src_sel),
        .ext_source_code(5'h03), .request_enable(req_en), .channel_enable(chan_en),
        .other_req(other_req), .chan_top(chan_top), .chan_req(chan_req),
        .chan_low_pri(chan_low_pri), .burst_start(burst_start),
        .burst_done(burst_done), .burst_active(burst_active));
    edr_periph u_edr_periph (.clk_sys(clk_sys), .dma_gnt_n(dma_gnt_n), .go(go),
        .dma_req_n(dma_req_n));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t grant side mismatch", $time);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // misconfigured channel must not grant
    task automatic s_refused;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(5);
        burst_start = 1'b1;
        chan_top = 1'b1;
        tick(1);
        burst_start = 1'b0;
        tick(1);
        chk(dma_gnt_n, 1'b1);
    endtask
    // early done is deferred; grant holds minimum, then one burst only
    task automatic s_burst;
        int n;
        src_sel = 5'h03;
        chan_en = 1'b1;
        for (n = 0; n < 20 && chan_req !== 1'b1; n++) tick(1);
        chk(chan_req, 1'b1);
        burst_start = 1'b1;
        burst_done = 1'b1;
        tick(1);
        burst_start = 1'b0;
        chk(dma_gnt_n, 1'b0);
        chk(burst_active, 1'b1);
        for (n = 0; n < 7; n++) begin
            tick(1);
            chk(dma_gnt_n, 1'b0);
        end
        for (n = 0; n < 4 && dma_gnt_n !== 1'b1; n++) tick(1);
        chk(dma_gnt_n, 1'b1);
        burst_done = 1'b0;
        for (n = 0; n < 3 && chan_low_pri !== 1'b1; n++) tick(1);
        chk(chan_low_pri, 1'b1);
        for (n = 0; n < 6; n++) begin
            tick(1);
            chk(chan_req, 1'b0);
        end
        other_req = 1'b0;
        tick(1);
        chk(chan_low_pri, 1'b0);
        other_req = 1'b1;
    endtask
    // clock enable low freezes sync and sequencer; release resumes them
    task automatic s_freeze;
        int n;
        clk_en = 1'b0;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (n = 0; n < 6; n++) begin
            tick(1);
            chk(chan_req, 1'b0);
        end
        clk_en = 1'b1;
        for (n = 0; n < 6 && chan_req !== 1'b1; n++) tick(1);
        chk(chan_req, 1'b1);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        tick(5);
        chk(dma_gnt_n, 1'b1);
        chk(burst_active, 1'b0);
        srst = 1'b0;
        s_refused();
        s_burst();
        s_freeze();
        results();
    end
endmodule // tb_top
`default_nettype wire
